// file: hdl/rds_device.sv
// Relay driver serial slave: framing, shift register, length check and register load
// Contract
// - Deselected: ignore clock and input, output released
// - Select fall loads response into shift register
// - Before first clock output shows error OR input
// - Sleeping: output stays released, no transfer
// - Decode only at 16 plus a non-zero multiple-of-8 clocks
// - Bad length sets error flag, command dropped
// - Valid frame loads addressed register at select rise
// - Sample input on falling, advance output on rising
// - Master keeps clock low at select edges
// - Bits travel most significant first
// - Frame holds control bits then data bits
// - Response shifts out MSB first after rising
// - One shift register passes data down the chain
// - Own frame done after sixteen clocks
// - Single device: master raises select at end
// - Chain: shift summed widths, then raise select
// - Response comes in the following frame
// - Prefixes 11 and 00 are syntax errors
`timescale 1ns/10ps
`include "rds_regs.svh"
module rds_device import rds_pkg::*; (
	// System
	input wire logic clk,
	input wire logic rst,
	// Serial link
	rds_if.device link,
	// Device state and register read data
	input wire logic sleep,
	input wire logic [7:0] rd_data,
	// Register write port
	output logic wr_strobe,
	output logic [5:0] wr_addr,
	output logic [7:0] wr_data,
	// Register read request
	output logic rd_strobe,
	output logic [5:0] rd_addr,
	// Status
	output logic frame_error_flag,
	output logic syntax_error
);
	rds_dev_state_t state;
	rds_dev_state_t next_state;
	logic sel_lvl;
	logic sel_rise;
	logic sel_fall;
	logic sclk_lvl;
	logic sclk_rise;
	logic sclk_fall;
	logic sdi_lvl;
	logic [`RDS_WORD_W-1:0] shreg;
	logic [`RDS_WORD_W-1:0] next_shreg;
	logic [`RDS_WORD_W-1:0] resp;
	logic [`RDS_WORD_W-1:0] next_resp;
	logic [`RDS_CNT_W-1:0] clk_cnt;
	logic [`RDS_CNT_W-1:0] next_clk_cnt;
	logic edge_bad;
	logic next_edge_bad;
	logic rd_pend;
	logic next_rd_pend;
	logic sdo;
	logic next_sdo;
	logic sdo_oe_n;
	logic next_sdo_oe_n;
	logic next_wr_strobe;
	logic [5:0] next_wr_addr;
	logic [7:0] next_wr_data;
	logic next_rd_strobe;
	logic [5:0] next_rd_addr;
	logic next_frame_error_flag;
	logic next_syntax_error;
	logic [1:0] cmd;

	// ==========================================
	// Frame length test: 16 own clocks plus whole bytes, at least one byte
	function automatic logic frame_len_ok(input logic [`RDS_CNT_W-1:0] n);
		frame_len_ok = (n >= `RDS_MIN_CLKS) && (n[2:0] == 3'h0) && (n != `RDS_CNT_MAX);
	endfunction

	// ==========================================
	// Pin synchronisers; the link clock is sampled like any pin
	rds_edge_sync #(.INIT(1'b1)) u_sel (
		.clk(clk),
		.rst(rst),
		.din(link.select_n),
		.level(sel_lvl),
		.rise(sel_rise),
		.fall(sel_fall)
	);
	rds_edge_sync #(.INIT(1'b0)) u_sclk (
		.clk(clk),
		.rst(rst),
		.din(link.sclk),
		.level(sclk_lvl),
		.rise(sclk_rise),
		.fall(sclk_fall)
	);
	rds_edge_sync #(.INIT(1'b0)) u_sdi (
		.clk(clk),
		.rst(rst),
		.din(link.master_data_out),
		.level(sdi_lvl),
		.rise(),
		.fall()
	);

	assign cmd = shreg[`RDS_CMD_HI:`RDS_CMD_LO];

	// ==========================================
	// Next-state logic of the frame engine
	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_resp = resp;
		next_clk_cnt = clk_cnt;
		next_edge_bad = edge_bad;
		next_rd_pend = 1'b0;
		next_sdo = sdo;
		next_sdo_oe_n = sdo_oe_n;
		next_wr_strobe = 1'b0;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_rd_strobe = 1'b0;
		next_rd_addr = rd_addr;
		next_frame_error_flag = frame_error_flag;
		next_syntax_error = syntax_error;
		// Read data is taken in the cycle the read strobe is high
		if (rd_pend) begin
			next_resp[`RDS_DATA_HI:0] = rd_data;
		end
		case (state)
			DS_IDLE: begin
				next_sdo_oe_n = 1'b1;
				next_clk_cnt = '0;
				// A sleeping device never starts a frame
				if (sel_fall && !sleep) begin
					next_state = DS_SHIFT;
					next_shreg = resp;
					next_clk_cnt = '0;
					next_edge_bad = sclk_lvl;
					next_sdo_oe_n = 1'b0;
					next_sdo = frame_error_flag | sdi_lvl;
				end
			end
			DS_SHIFT: begin
				if (sleep) begin
					// Sleep entered mid-frame: release and drop the frame
					next_state = DS_IDLE;
					next_sdo_oe_n = 1'b1;
				end else if (sel_rise) begin
					next_state = DS_IDLE;
					next_sdo_oe_n = 1'b1;
					if (!frame_len_ok(clk_cnt) || edge_bad || sclk_lvl) begin
						next_frame_error_flag = 1'b1;
						next_resp = `RDS_RESP_LEN_ERR;
					end else begin
						next_frame_error_flag = 1'b0;
						// Last sixteen bits shifted in are this device's own word
						if (cmd == `RDS_CMD_WRITE) begin
							next_syntax_error = 1'b0;
							next_wr_strobe = 1'b1;
							next_wr_addr = shreg[`RDS_ADDR_HI:`RDS_ADDR_LO];
							next_wr_data = shreg[`RDS_DATA_HI:0];
							next_resp = shreg;
						end else if (cmd == `RDS_CMD_READ) begin
							next_syntax_error = 1'b0;
							next_rd_strobe = 1'b1;
							next_rd_pend = 1'b1;
							next_rd_addr = shreg[`RDS_ADDR_HI:`RDS_ADDR_LO];
							next_resp = shreg;
						end else begin
							next_syntax_error = 1'b1;
							next_resp = `RDS_RESP_SYNTAX;
						end
					end
				end else begin
					// Until the first rising clock the output follows error OR input;
					// once the clock has risen the shifted bit must not be overwritten
					if (clk_cnt == '0 && !sclk_lvl && !sclk_fall) begin
						next_sdo = frame_error_flag | sdi_lvl;
					end
					if (sclk_rise) begin
						next_sdo = shreg[`RDS_WORD_W-1];
					end
					if (sclk_fall) begin
						next_shreg = {shreg[`RDS_WORD_W-2:0], sdi_lvl};
						if (clk_cnt != `RDS_CNT_MAX) begin
							next_clk_cnt = clk_cnt + 8'h01;
						end
					end
				end
			end
			default: begin
				next_state = DS_IDLE;
				next_sdo_oe_n = 1'b1;
			end
		endcase
	end

	// ==========================================
	// Frame engine registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= DS_IDLE;
			shreg <= `RDS_RESP_RESET;
			resp <= `RDS_RESP_RESET;
			clk_cnt <= '0;
			edge_bad <= 1'b0;
			rd_pend <= 1'b0;
			sdo <= 1'b0;
			sdo_oe_n <= 1'b1;
			wr_strobe <= 1'b0;
			wr_addr <= 6'h00;
			wr_data <= 8'h00;
			rd_strobe <= 1'b0;
			rd_addr <= 6'h00;
			frame_error_flag <= 1'b0;
			syntax_error <= 1'b0;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			resp <= next_resp;
			clk_cnt <= next_clk_cnt;
			edge_bad <= next_edge_bad;
			rd_pend <= next_rd_pend;
			sdo <= next_sdo;
			sdo_oe_n <= next_sdo_oe_n;
			wr_strobe <= next_wr_strobe;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			rd_strobe <= next_rd_strobe;
			rd_addr <= next_rd_addr;
			frame_error_flag <= next_frame_error_flag;
			syntax_error <= next_syntax_error;
		end
	end

	// Pin drivers straight from flip-flops
	assign link.sdo = sdo;
	assign link.sdo_oe_n = sdo_oe_n;
endmodule

// file: hdl/rds_edge_sync.sv
// Two-stage synchroniser with edge detection on the synchronised level
`timescale 1ns/10ps
module rds_edge_sync #(
	parameter logic INIT = 1'b0
) (
	// System
	input wire logic clk,
	input wire logic rst,
	// Asynchronous input
	input wire logic din,
	// Synchronised results
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic sync;
	logic prev;
	logic next_meta;
	logic next_sync;
	logic next_prev;

	// ==========================================
	// Stage chain; only the second stage reads the first
	always_comb begin
		next_meta = din;
		next_sync = meta;
		next_prev = sync;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= INIT;
			sync <= INIT;
			prev <= INIT;
		end else begin
			meta <= next_meta;
			sync <= next_sync;
			prev <= next_prev;
		end
	end

	assign level = sync;
	assign rise = sync & ~prev;
	assign fall = ~sync & prev;
endmodule

// file: hdl/rds_if.sv
// Serial link between the bus master and the relay driver slave
`timescale 1ns/10ps
interface rds_if;
	logic select_n;
	logic sclk;
	logic master_data_out;
	logic sdo;
	logic sdo_oe_n;
	logic master_data_in;

	// Released output is modelled as pulled high
	assign master_data_in = sdo_oe_n ? 1'b1 : sdo;

	modport device (
		input select_n,
		input sclk,
		input master_data_out,
		output sdo,
		output sdo_oe_n
	);
	modport master (
		output select_n,
		output sclk,
		output master_data_out,
		input master_data_in
	);
endinterface

// file: hdl/rds_master.sv
// Bus master end: makes the link clock and shifts whole-byte frames
`timescale 1ns/10ps
`include "rds_regs.svh"
module rds_master import rds_pkg::*; (
	// System
	input wire logic clk,
	input wire logic rst,
	// Serial link
	rds_if.master link,
	// Frame request
	input wire logic start,
	input wire logic [31:0] tx_word,
	input wire logic [2:0] nbytes,
	// Frame result
	output logic busy,
	output logic done,
	output logic [31:0] rx_word
);
	rds_mst_state_t state;
	rds_mst_state_t next_state;
	logic [7:0] timer;
	logic [7:0] next_timer;
	logic [5:0] bits_left;
	logic [5:0] next_bits_left;
	logic [31:0] txsh;
	logic [31:0] next_txsh;
	logic [31:0] next_rx_word;
	logic select_n;
	logic next_select_n;
	logic sclk;
	logic next_sclk;
	logic mosi;
	logic next_mosi;
	logic next_busy;
	logic next_done;
	logic miso_lvl;

	// ==========================================
	// Returned data is a pin from outside this clock domain
	rds_edge_sync #(.INIT(1'b1)) u_miso (
		.clk(clk),
		.rst(rst),
		.din(link.master_data_in),
		.level(miso_lvl),
		.rise(),
		.fall()
	);

	// ==========================================
	// Frame sequencer; clock stays low around select edges
	always_comb begin
		next_state = state;
		next_timer = (timer != 8'h00) ? timer - 8'h01 : 8'h00;
		next_bits_left = bits_left;
		next_txsh = txsh;
		next_rx_word = rx_word;
		next_select_n = select_n;
		next_sclk = sclk;
		next_mosi = mosi;
		next_busy = busy;
		next_done = 1'b0;
		case (state)
			MS_IDLE: begin
				if (start) begin
					next_state = MS_LEAD;
					next_busy = 1'b1;
					next_select_n = 1'b0;
					next_txsh = tx_word;
					next_mosi = tx_word[31];
					next_bits_left = {nbytes, 3'h0};
					next_rx_word = 32'h0000_0000;
					next_timer = 8'(`RDS_LEAD_CYC);
				end
			end
			MS_LEAD: begin
				if (timer == 8'h00) begin
					next_state = MS_HIGH;
					next_sclk = 1'b1;
					next_timer = 8'(`RDS_HALF_CYC);
				end
			end
			MS_HIGH: begin
				// Falling edge: slave samples, master takes the returned bit
				if (timer == 8'h00) begin
					next_sclk = 1'b0;
					next_txsh = {txsh[30:0], 1'b0};
					next_rx_word = {rx_word[30:0], miso_lvl};
					next_bits_left = bits_left - 6'h01;
					// Last fall starts the lag time, the others a low half period
					next_timer = (bits_left == 6'h01) ? 8'(`RDS_LAG_CYC) : 8'(`RDS_HALF_CYC);
					next_state = (bits_left == 6'h01) ? MS_LAG : MS_LOW;
				end
			end
			MS_LOW: begin
				// Data changes on the rising edge, far from the sample point
				if (timer == 8'h00) begin
					next_state = MS_HIGH;
					next_sclk = 1'b1;
					next_mosi = txsh[31];
					next_timer = 8'(`RDS_HALF_CYC);
				end
			end
			MS_LAG: begin
				if (timer == 8'h00) begin
					next_state = MS_GAP;
					next_select_n = 1'b1;
					next_done = 1'b1;
					next_timer = 8'(`RDS_GAP_CYC);
				end
			end
			MS_GAP: begin
				if (timer == 8'h00) begin
					next_state = MS_IDLE;
					next_busy = 1'b0;
				end
			end
			default: begin
				next_state = MS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= MS_IDLE;
			timer <= 8'h00;
			bits_left <= 6'h00;
			txsh <= 32'h0000_0000;
			rx_word <= 32'h0000_0000;
			select_n <= 1'b1;
			sclk <= 1'b0;
			mosi <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			bits_left <= next_bits_left;
			txsh <= next_txsh;
			rx_word <= next_rx_word;
			select_n <= next_select_n;
			sclk <= next_sclk;
			mosi <= next_mosi;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign link.select_n = select_n;
	assign link.sclk = sclk;
	assign link.master_data_out = mosi;
endmodule

// file: hdl/rds_pkg.sv
// Types shared by both ends of the relay driver serial link
package rds_pkg;
	typedef enum logic [0:0] {DS_IDLE, DS_SHIFT} rds_dev_state_t;
	typedef enum logic [2:0] {MS_IDLE, MS_LEAD, MS_LOW, MS_HIGH, MS_LAG, MS_GAP} rds_mst_state_t;
endpackage

// file: hdl/rds_regs.svh
// Constants of the relay driver serial link: field positions, reset values and timing counts
`ifndef RDS_REGS_SVH
`define RDS_REGS_SVH

// ==========================================
// Frame layout
`define RDS_WORD_W 16
`define RDS_CNT_W 8
`define RDS_CNT_MAX 8'hff
`define RDS_OWN_CLKS 8'h10
`define RDS_MIN_CLKS 8'h18
`define RDS_CMD_HI 15
`define RDS_CMD_LO 14
`define RDS_ADDR_HI 13
`define RDS_ADDR_LO 8
`define RDS_DATA_HI 7
`define RDS_CMD_WRITE 2'h2
`define RDS_CMD_READ 2'h1

// ==========================================
// Reset and special response words
`define RDS_RESP_RESET 16'h0000
`define RDS_RESP_LEN_ERR 16'h0000
`define RDS_RESP_SYNTAX 16'hc000

// ==========================================
// Master timing, in ns at a 10 ns system clock
`define RDS_CLK_NS 10
`define RDS_SCLK_PERIOD_NS 200
`define RDS_LEAD_NS 200
`define RDS_LAG_NS 200
`define RDS_GAP_NS 250
`define RDS_HALF_CYC ((`RDS_SCLK_PERIOD_NS / 2 + `RDS_CLK_NS - 1) / `RDS_CLK_NS)
`define RDS_LEAD_CYC ((`RDS_LEAD_NS + `RDS_CLK_NS - 1) / `RDS_CLK_NS)
`define RDS_LAG_CYC ((`RDS_LAG_NS + `RDS_CLK_NS - 1) / `RDS_CLK_NS)
`define RDS_GAP_CYC ((`RDS_GAP_NS + `RDS_CLK_NS - 1) / `RDS_CLK_NS)

`endif

// file: tb/rds_link_props.sv
// Concurrent checks on the serial link between master and device
`timescale 1ns/10ps
module rds_link_props (
	// System
	input wire logic clk,
	input wire logic rst,
	// Link
	input wire logic select_n,
	input wire logic sclk,
	input wire logic master_data_out,
	input wire logic sdo,
	input wire logic sdo_oe_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	logic sclk_q;
	logic [7:0] rises;
	logic [7:0] next_rises;
	// ==========================================
	// Clock pulses seen in the current frame
	always_comb begin
		next_rises = select_n ? 8'h00 : rises + {7'h00, sclk & ~sclk_q};
	end
	always_ff @(posedge clk) begin
		sclk_q <= rst ? 1'b0 : sclk;
		rises <= rst ? 8'h00 : next_rises;
	end
	// ==========================================
	// Properties
	chk_idle_released: assert property (select_n [*5] |-> sdo_oe_n)
		else $error("sdo driven while deselected");
	chk_release_time: assert property ($rose(select_n) |-> ##[1:5] sdo_oe_n)
		else $error("sdo not released after select rise");
	chk_enable_select: assert property ($fell(sdo_oe_n) |-> !select_n && $past(!select_n, 2))
		else $error("sdo enabled without select");
	chk_sdo_on_rise: assert property (!sdo_oe_n && $past(!sdo_oe_n) && $changed(sdo)
		|-> $past(sclk, 2))
		else $error("sdo moved without rising clock");
	chk_lead_low: assert property ($fell(select_n) |-> !sclk [*8])
		else $error("clock high at select fall");
	chk_lag_low: assert property ($rose(select_n) |-> !sclk && $past(!sclk, 8))
		else $error("clock high at select rise");
	chk_sclk_idle: assert property (select_n |-> !sclk)
		else $error("clock runs outside frame");
	chk_mosi_rise: assert property (!select_n && $past(!select_n)
		&& $changed(master_data_out) |-> $rose(sclk))
		else $error("data changed off rising clock");
	chk_frame_bytes: assert property ($rose(select_n) |-> rises[2:0] == 3'h0 && rises >= 8'h10)
		else $error("frame not whole bytes");
endmodule

// file: tb/relay_driver_spi_slave_tb.sv
// Self-checking bench: master and device joined over the serial link
`timescale 1ns/10ps
module relay_driver_spi_slave_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [31:0] tx_word = 32'h0;
	logic [2:0] nbytes = 3'h3;
	logic busy;
	logic done;
	logic [31:0] rx_word;
	logic sleep = 1'b0;
	logic [7:0] rd_val = 8'h5a;
	logic wr_strobe;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	logic rd_strobe;
	logic [5:0] rd_addr;
	logic flag;
	logic syn_err;
	logic flag2;
	logic wr2;
	logic lead_bit;
	int wr_n, rd_n, wr2_n, oe_seen, done_n, cyc, bad_count, num_checks;
	rds_if lk();
	rds_if lk2();
	rds_master rds_master_i (.clk(clk), .rst(rst), .link(lk.master), .start(start),
		.tx_word(tx_word), .nbytes(nbytes), .busy(busy), .done(done), .rx_word(rx_word));
	rds_device rds_device_i (.clk(clk), .rst(rst), .link(lk.device), .sleep(sleep),
		.rd_data(rd_val), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_strobe(rd_strobe), .rd_addr(rd_addr), .frame_error_flag(flag), .syntax_error(syn_err));
	// Second device, driven directly to break the clock rule
	rds_device rds_device_i2 (.clk(clk), .rst(rst), .link(lk2.device), .sleep(1'b0),
		.rd_data(8'h00), .wr_strobe(wr2), .wr_addr(), .wr_data(), .rd_strobe(), .rd_addr(),
		.frame_error_flag(flag2), .syntax_error());
	rds_link_props rds_link_props_i (.clk(clk), .rst(rst), .select_n(lk.select_n),
		.sclk(lk.sclk), .master_data_out(lk.master_data_out), .sdo(lk.sdo), .sdo_oe_n(lk.sdo_oe_n));

	always #5 clk = ~clk;

	// Strobe, enable and timeout monitors
	always @(posedge clk) begin
		cyc++;
		if (wr_strobe === 1'b1)
			wr_n++;
		if (rd_strobe === 1'b1)
			rd_n++;
		if (wr2 === 1'b1)
			wr2_n++;
		if (lk.sdo_oe_n === 1'b0)
			oe_seen++;
		if (done === 1'b1)
			done_n++;
		if (cyc == 20000) begin
			bad_count++;
			$display("[FAIL] cycle limit expected %0d seen %0d", 20000, cyc);
			wrap_up();
		end
	end

	task wrap_up();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One master frame; samples the line during the lead time
	task automatic xfer(input logic [31:0] w, input logic [2:0] nb);
		int n;
		n = 0;
		wr_n = 0;
		rd_n = 0;
		oe_seen = 0;
		done_n = 0;
		start = 1'b1;
		tx_word = w;
		nbytes = nb;
		@(negedge clk);
		start = 1'b0;
		while (lk.select_n !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		repeat (8) @(negedge clk);
		lead_bit = lk.master_data_in;
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		repeat (2) @(negedge clk);
		chk("done count", 32'h1, done_n);
	endtask

	task t_write_read();
		xfer({8'h3c, 16'h95a7, 8'h00}, 3'h3);
		chk("lead bit", 32'h0, lead_bit);
		chk("write count", 32'h1, wr_n);
		chk("write addr", {26'h0, 6'h15}, {26'h0, wr_addr});
		chk("write data", 32'ha7, {24'h0, wr_data});
		xfer({8'hc3, 16'h4a00, 8'h00}, 3'h3);
		chk("echo", {8'h0, 16'h95a7, 8'hc3}, {8'h0, rx_word[23:0]});
		chk("read addr", 32'h0a, {26'h0, rd_addr});
		chk("read count", 32'h1, rd_n);
		xfer({8'h00, 16'h4100, 8'h00}, 3'h3);
		chk("read reply", {16'h0, 8'h4a, rd_val}, {16'h0, rx_word[23:8]});
	endtask

	task t_length();
		xfer({16'h95a7, 16'h0000}, 3'h2);
		chk("length flag", 32'h1, flag);
		chk("length write", 32'h0, wr_n);
		xfer({16'h95a7, 16'h0000}, 3'h2);
		chk("length again", 32'h0, wr_n);
		xfer({8'h00, 16'h4100, 8'h00}, 3'h3);
		chk("flag or input", 32'h1, lead_bit);
		chk("length reply", 32'h0, {16'h0, rx_word[23:8]});
		chk("flag cleared", 32'h0, flag);
	endtask

	task automatic t_syntax();
		logic [15:0] bad [2] = '{16'hd5a7, 16'h15a7};
		for (int i = 0; i < 2; i++) begin
			xfer({8'h00, bad[i], 8'h00}, 3'h3);
			chk("syntax flag", 32'h1, syn_err);
			chk("syntax strobes", 32'h0, wr_n + rd_n);
			xfer({8'h00, 16'h4100, 8'h00}, 3'h3);
			chk("syntax reply", 32'hc000, {16'h0, rx_word[23:8]});
		end
	endtask

	task t_chain();
		xfer({16'h1234, 16'h9633}, 3'h4);
		chk("chain addr", 32'h16, {26'h0, wr_addr});
		chk("chain data", 32'h33, {24'h0, wr_data});
		xfer({16'habcd, 16'h4100}, 3'h4);
		chk("chain pass", {16'h9633, 16'habcd}, rx_word);
	endtask

	task t_sleep();
		sleep = 1'b1;
		xfer({8'h00, 16'h95a7, 8'h00}, 3'h3);
		chk("sleep enable", 32'h0, oe_seen);
		chk("sleep write", 32'h0, wr_n);
		chk("sleep line", 32'h1, lead_bit);
		sleep = 1'b0;
	endtask

	// Clock held high across both select edges
	task automatic t_bad_edge();
		logic [23:0] w;
		w = {8'h00, 16'h95a7};
		lk2.sclk = 1'b1;
		repeat (4) @(negedge clk);
		lk2.select_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			lk2.master_data_out = w[i];
			repeat (4) @(negedge clk);
			lk2.sclk = 1'b0;
			repeat (4) @(negedge clk);
			lk2.sclk = 1'b1;
		end
		repeat (4) @(negedge clk);
		lk2.select_n = 1'b1;
		repeat (4) @(negedge clk);
		lk2.sclk = 1'b0;
		lk2.master_data_out = ~w[0];
		repeat (10) @(negedge clk);
		chk("edge flag", 32'h1, flag2);
		chk("edge write", 32'h0, wr2_n);
	endtask

	initial begin
		lk2.select_n = 1'b1;
		lk2.sclk = 1'b0;
		lk2.master_data_out = 1'b0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_write_read();
		t_length();
		t_syntax();
		t_chain();
		t_sleep();
		t_bad_edge();
		wrap_up();
	end
endmodule
